// File: core/sfm_consts.svh
`ifndef SFM_CONSTS_SVH
`define SFM_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SFM_CLK_PERIOD_NS 10
`define SFM_RESET_PULSE_MIN_NS 1000
`define SFM_RESET_CYCLES ((`SFM_RESET_PULSE_MIN_NS + `SFM_CLK_PERIOD_NS - 1) / `SFM_CLK_PERIOD_NS)
`define SFM_RST_CNT_W 8

// ----------------------------------------
// Array organisation
// ----------------------------------------
`define SFM_MAIN_BYTES 8388608
`define SFM_ADDR_W 23
`define SFM_MAIN_TOP 24'h800000
`define SFM_SECTOR_MASK 23'h000fff
`define SFM_BLOCK_MASK 23'h00ffff
`define SFM_CHIP_LAST 23'h7fffff
`define SFM_SEC_BYTES 4096
`define SFM_SEC_IDX_W 12
`define SFM_REGION_MASK 12'h3ff
`define SFM_SECTOR_SHIFT 5'd12
`define SFM_BLOCK_SHIFT 5'd16
`define SFM_ERASED 8'hff

// ----------------------------------------
// Link framing
// ----------------------------------------
`define SFM_OP_BITS 5'd8
`define SFM_ADDR_BITS 5'd24
`define SFM_DUMMY_CLKS 5'd8

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SFM_OP_WREN 8'h06
`define SFM_OP_WRDI 8'h04
`define SFM_OP_RDSR1 8'h05
`define SFM_OP_RDSR2 8'h35
`define SFM_OP_WRSR 8'h01
`define SFM_OP_READ 8'h03
`define SFM_OP_FREAD 8'h0b
`define SFM_OP_DREAD 8'h3b
`define SFM_OP_QREAD 8'h6b
`define SFM_OP_PP 8'h02
`define SFM_OP_QPP 8'h32
`define SFM_OP_SE 8'h20
`define SFM_OP_BE 8'hd8
`define SFM_OP_CE1 8'hc7
`define SFM_OP_CE2 8'h60
`define SFM_OP_SECRD 8'h48
`define SFM_OP_SECPP 8'h42
`define SFM_OP_SECER 8'h44
`define SFM_OP_DISC 8'h5a

// ----------------------------------------
// Register port map and fields
// ----------------------------------------
`define SFM_REG_STATUS1 2'h0
`define SFM_REG_STATUS2 2'h1
`define SFM_REG_STATE 2'h2
`define SFM_REG_CTRL 2'h3
`define SFM_CTRL_QPI 0

`endif

// File: core/sfm_flash.sv
// Function
// R1: Sample input line on serial clock rise
// R2: Drive output line on serial clock fall
// R3: Wide commands: lines in on rise, out on fall
// R4: Standard/dual use lines 0-1, quad all four
// R5: Select high: deselected, outputs high impedance
// R6: Ignore instructions until first select falling edge
// R7: Internal erase/program/status cycle survives deselect
// R8: Write protect low blocks status register writes
// R9: Quad enable turns write protect into line two
// R10: Function select 0: line three is pause
// R11: Pause while selected: tristate, ignore clock, data
// R12: Quad enable: line three is data, no pause
// R13: Function select 1, no quad: line three resets
// R14: Reset low 1us aborts every operation
// R15: Dedicated reset pin works regardless of quad
// R16: Array 8 MiB: blocks, sectors, pages
// R17: Program one page, only ones to zeros
// R18: Sector, block, chip erase; no page erase
// R19: Sectors aligned 4 KiB spans
// R20: Security lock bits one-time, never cleared; the model clears them on srst
// R21: Three 1 KiB security regions, separate space
// R22: Security regions erased/programmed/locked independently
// R23: Region zero holds discovery data, readable
// R24: Discovery read opcode 5Ah, read-only space
// R25: Partial instruction at deselect is discarded
`timescale 1ns/10ps
`default_nettype none
`include "sfm_consts.svh"

module sfm_flash #(
  parameter int MAIN_BYTES = `SFM_MAIN_BYTES,
  parameter int RESET_CYCLES = `SFM_RESET_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  // Serial link
  input wire logic serial_clk,
  input wire logic select_n,
  input wire logic dedicated_reset_n,
  input wire logic data_line_zero_in,
  output logic data_line_zero_out,
  output logic data_line_zero_oe,
  input wire logic data_line_one_in,
  output logic data_line_one_out,
  output logic data_line_one_oe,
  input wire logic data_line_two_in,
  output logic data_line_two_out,
  output logic data_line_two_oe,
  input wire logic data_line_three_in,
  output logic data_line_three_out,
  output logic data_line_three_oe,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] main_mem [0:MAIN_BYTES-1]; // R16
  logic [7:0] sec_mem [0:`SFM_SEC_BYTES-1]; // R21
  sfm_pkg::sfm_state_t r;
  sfm_pkg::sfm_state_t next_r;
  sfm_pkg::sfm_pins_t pins;
  logic mem_we;
  logic [22:0] mem_a;
  logic [7:0] mem_d;
  logic sec_we;
  logic [11:0] sec_a;
  logic [7:0] sec_d;
  logic rise;
  logic fall;
  logic paused;
  logic rst_low;
  logic wp_blk;
  logic [2:0] w;
  logic [3:0] inb;
  logic [7:0] byte_in;
  logic [4:0] cnt_w;
  logic [7:0] rd_byte;
  logic [1:0] region;
  logic region_ok;
  logic [7:0] sr1;
  logic [7:0] sr2;

  // Erased at start; nonvolatile contents ignore srst
  initial begin
    for (int i = 0; i < MAIN_BYTES; i++) begin
      main_mem[i] = `SFM_ERASED;
    end
    for (int i = 0; i < `SFM_SEC_BYTES; i++) begin
      sec_mem[i] = `SFM_ERASED;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic prot(input logic [22:0] a, input logic [2:0] bp,
                                input logic tb, input logic sec, input logic cmp);
    logic [4:0] sh;
    logic [23:0] size;
    logic hit;
    sh = (sec ? `SFM_SECTOR_SHIFT : `SFM_BLOCK_SHIFT) + {2'b00, bp} - 5'd1;
    size = 24'h1 << sh;
    if (bp == 3'h0) begin
      hit = 1'b0;
    end else if (tb) begin
      hit = {1'b0, a} < size;
    end else begin
      hit = {1'b0, a} >= (`SFM_MAIN_TOP - size);
    end
    return hit ^ cmp;
  endfunction : prot

  function automatic logic [2:0] lanes(input logic quad_command_phase_mode, input logic [7:0] op);
    if (quad_command_phase_mode) begin
      return 3'd4; // R4
    end
    case (op)
      `SFM_OP_DREAD: return 3'd2; // R4
      `SFM_OP_QREAD, `SFM_OP_QPP: return 3'd4; // R4
      default: return 3'd1;
    endcase
  endfunction : lanes

  function automatic logic [3:0] nib(input logic [7:0] b, input logic [2:0] wd);
    case (wd)
      3'd4: return b[7:4];
      3'd2: return {2'b00, b[7:6]};
      default: return {2'b00, b[7], 1'b0};
    endcase
  endfunction : nib

  function automatic sfm_pkg::sfm_state_t wr_sr(input sfm_pkg::sfm_state_t s,
                                                input logic idx, input logic [7:0] b);
    sfm_pkg::sfm_state_t o;
    o = s;
    if (!idx) begin
      o.bp = b[4:2];
      o.tb = b[5];
      o.sec = b[6];
      o.status_protect_bits = b[7];
    end else begin
      o.qe = b[1];
      o.pfs = b[2];
      o.lock = s.lock | b[5:3]; // R20
      o.cmp = b[6];
    end
    return o;
  endfunction : wr_sr

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    pins = '{sclk: serial_clk, sel_n: select_n, rst_n: dedicated_reset_n,
             io: {data_line_three_in, data_line_two_in, data_line_one_in, data_line_zero_in}};
    next_r = r;
    mem_we = 1'b0;
    mem_a = '0;
    mem_d = `SFM_ERASED;
    sec_we = 1'b0;
    sec_a = '0;
    sec_d = `SFM_ERASED;
    next_r.s1 = pins;
    next_r.s2 = r.s1;
    next_r.sclk_q = r.s2.sclk;
    next_r.sel_q = r.s2.sel_n;
    rise = r.s2.sclk & ~r.sclk_q;
    fall = ~r.s2.sclk & r.sclk_q;
    paused = !r.pfs && !r.qe && !r.s2.io[3] && !r.s2.sel_n; // R10 R11 R12
    rst_low = !r.s2.rst_n || (r.pfs && !r.qe && !r.s2.io[3]); // R13 R15
    wp_blk = !r.qe && !r.s2.io[2]; // R8 R9
    sr1 = {r.status_protect_bits, r.sec, r.tb, r.bp, r.wel, r.busy};
    sr2 = {1'b0, r.cmp, r.lock, r.pfs, r.qe, 1'b0};
    region = r.adr[13:12];
    region_ok = (region != 2'b00) && !r.lock[region - 2'd1]; // R22 R24
    case (r.phase)
      sfm_pkg::ph_cmd: w = r.quad_command_phase_mode ? 3'd4 : 3'd1;
      sfm_pkg::ph_addr: w = r.quad_command_phase_mode ? 3'd4 : 3'd1;
      sfm_pkg::ph_data: w = lanes(r.quad_command_phase_mode, r.op);
      default: w = 3'd1;
    endcase
    case (w)
      3'd4: inb = r.s2.io; // R3
      3'd2: inb = {2'b00, r.s2.io[1:0]}; // R3
      default: inb = {3'b000, r.s2.io[0]}; // R1
    endcase
    byte_in = 8'(r.shin << w) | {4'h0, inb};
    cnt_w = r.cnt + {2'b00, w};
    case (r.op)
      `SFM_OP_RDSR1: rd_byte = sr1;
      `SFM_OP_RDSR2: rd_byte = sr2;
      `SFM_OP_SECRD: rd_byte = sec_mem[{region, r.adr[9:0]}]; // R21
      `SFM_OP_DISC: rd_byte = sec_mem[{4'h0, r.adr[7:0]}]; // R23 R24
      default: rd_byte = main_mem[r.adr[22:0]];
    endcase

    // Erase engine runs regardless of select
    if (r.busy) begin // R7
      if (r.busy_sec) begin
        sec_we = 1'b1;
        sec_a = r.eptr[11:0];
      end else begin
        mem_we = 1'b1;
        mem_a = r.eptr;
      end
      if (r.eptr == r.eend) begin
        next_r.busy = 1'b0;
      end else begin
        next_r.eptr = r.eptr + 23'h1;
      end
    end

    // Register port
    next_r.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `SFM_REG_STATUS1: next_r.rdata = sr1;
        `SFM_REG_STATUS2: next_r.rdata = sr2;
        `SFM_REG_STATE: next_r.rdata = {4'h0, r.rst_act, paused, r.armed, r.busy};
        default: next_r.rdata = {7'h00, r.quad_command_phase_mode};
      endcase
    end
    if (reg_wr) begin
      case (reg_addr)
        `SFM_REG_STATUS1: next_r = wp_blk ? next_r : wr_sr(next_r, 1'b0, reg_wdata); // R8
        `SFM_REG_STATUS2: next_r = wp_blk ? next_r : wr_sr(next_r, 1'b1, reg_wdata); // R8
        `SFM_REG_CTRL: next_r.quad_command_phase_mode = reg_wdata[`SFM_CTRL_QPI];
        default: next_r.quad_command_phase_mode = r.quad_command_phase_mode;
      endcase
    end

    // Link
    if (r.s2.sel_n) begin
      next_r.phase = sfm_pkg::ph_idle;
      next_r.oe_mask = 4'h0; // R5
      if (!r.sel_q && r.cmd_ok) begin // R25
        next_r.cmd_ok = 1'b0;
        case (r.op)
          `SFM_OP_WREN: next_r.wel = 1'b1;
          `SFM_OP_WRDI: next_r.wel = 1'b0;
          `SFM_OP_SE, `SFM_OP_BE: begin // R18
            next_r.wel = 1'b0;
            if (r.wel && !r.busy && !prot(r.adr[22:0], r.bp, r.tb, r.sec, r.cmp)) begin
              next_r.busy = 1'b1;
              next_r.busy_sec = 1'b0;
              if (r.op == `SFM_OP_SE) begin
                next_r.eptr = r.adr[22:0] & ~`SFM_SECTOR_MASK; // R19
                next_r.eend = r.adr[22:0] | `SFM_SECTOR_MASK; // R19
              end else begin
                next_r.eptr = r.adr[22:0] & ~`SFM_BLOCK_MASK;
                next_r.eend = r.adr[22:0] | `SFM_BLOCK_MASK;
              end
            end
          end
          `SFM_OP_CE1, `SFM_OP_CE2: begin // R18
            next_r.wel = 1'b0;
            if (r.wel && !r.busy && r.bp == 3'h0 && !r.cmp) begin
              next_r.busy = 1'b1;
              next_r.busy_sec = 1'b0;
              next_r.eptr = '0;
              next_r.eend = `SFM_CHIP_LAST;
            end
          end
          `SFM_OP_SECER: begin // R22
            next_r.wel = 1'b0;
            if (r.wel && !r.busy && region_ok) begin
              next_r.busy = 1'b1;
              next_r.busy_sec = 1'b1;
              next_r.eptr = {11'h000, region, 10'h000};
              next_r.eend = {11'h000, region, 10'h000} | {11'h000, `SFM_REGION_MASK};
            end
          end
          `SFM_OP_PP, `SFM_OP_QPP, `SFM_OP_SECPP, `SFM_OP_WRSR: next_r.wel = 1'b0;
          default: next_r.wel = r.wel;
        endcase
      end
    end else if (r.sel_q) begin
      next_r.armed = 1'b1; // R6
      next_r.phase = sfm_pkg::ph_cmd;
      next_r.cnt = '0;
      next_r.shin = '0;
      next_r.cmd_ok = 1'b0;
      next_r.st_idx = 1'b0;
    end else if (!paused && rise) begin // R1 R3 R11
      case (r.phase)
        sfm_pkg::ph_cmd: begin
          next_r.shin = byte_in;
          next_r.cnt = cnt_w;
          if (cnt_w == `SFM_OP_BITS) begin
            next_r.op = byte_in;
            next_r.cnt = '0;
            next_r.ocnt = '0;
            next_r.adr = '0;
            case (byte_in)
              `SFM_OP_WREN, `SFM_OP_WRDI, `SFM_OP_CE1, `SFM_OP_CE2, `SFM_OP_WRSR: begin
                next_r.phase = r.busy ? sfm_pkg::ph_idle : sfm_pkg::ph_data;
                next_r.cmd_ok = !r.busy;
              end
              `SFM_OP_RDSR1, `SFM_OP_RDSR2: next_r.phase = sfm_pkg::ph_data;
              `SFM_OP_READ, `SFM_OP_FREAD, `SFM_OP_DREAD, `SFM_OP_QREAD, `SFM_OP_PP,
              `SFM_OP_QPP, `SFM_OP_SE, `SFM_OP_BE, `SFM_OP_SECRD, `SFM_OP_SECPP,
              `SFM_OP_SECER, `SFM_OP_DISC:
                next_r.phase = r.busy ? sfm_pkg::ph_idle : sfm_pkg::ph_addr;
              default: next_r.phase = sfm_pkg::ph_idle;
            endcase
          end
        end
        sfm_pkg::ph_addr: begin
          next_r.adr = 24'(r.adr << w) | {20'h00000, inb};
          next_r.cnt = cnt_w;
          if (cnt_w == `SFM_ADDR_BITS) begin
            next_r.cnt = '0;
            next_r.cmd_ok = 1'b1;
            case (r.op)
              `SFM_OP_FREAD, `SFM_OP_DREAD, `SFM_OP_QREAD, `SFM_OP_SECRD, `SFM_OP_DISC:
                next_r.phase = sfm_pkg::ph_dummy;
              default: next_r.phase = sfm_pkg::ph_data;
            endcase
          end
        end
        sfm_pkg::ph_dummy: begin
          next_r.cnt = r.cnt + 5'd1;
          if (r.cnt + 5'd1 == `SFM_DUMMY_CLKS) begin
            next_r.cnt = '0;
            next_r.phase = sfm_pkg::ph_data;
          end
        end
        sfm_pkg::ph_data: begin
          next_r.shin = byte_in;
          next_r.cnt = cnt_w;
          if (cnt_w == `SFM_OP_BITS) begin // R25
            next_r.cnt = '0;
            next_r.adr = {r.adr[23:8], r.adr[7:0] + 8'h01}; // R17
            case (r.op)
              `SFM_OP_PP, `SFM_OP_QPP: begin
                if (r.wel && !prot(r.adr[22:0], r.bp, r.tb, r.sec, r.cmp)) begin
                  mem_we = 1'b1;
                  mem_a = r.adr[22:0];
                  mem_d = main_mem[r.adr[22:0]] & byte_in; // R17
                end
              end
              `SFM_OP_SECPP: begin
                if (r.wel && region_ok) begin // R20 R22
                  sec_we = 1'b1;
                  sec_a = {region, r.adr[9:0]};
                  sec_d = sec_mem[{region, r.adr[9:0]}] & byte_in; // R17
                end
              end
              `SFM_OP_WRSR: begin
                next_r.st_idx = 1'b1;
                if (r.wel && !wp_blk) begin // R8
                  next_r = wr_sr(next_r, r.st_idx, byte_in);
                end
              end
              default: next_r.adr = r.adr;
            endcase
          end
        end
        default: next_r.cnt = r.cnt;
      endcase
    end else if (!paused && fall && r.phase == sfm_pkg::ph_data) begin // R2 R3
      case (r.op)
        `SFM_OP_READ, `SFM_OP_FREAD, `SFM_OP_DREAD, `SFM_OP_QREAD, `SFM_OP_SECRD,
        `SFM_OP_DISC, `SFM_OP_RDSR1, `SFM_OP_RDSR2: begin
          case (w)
            3'd4: next_r.oe_mask = 4'hf; // R4
            3'd2: next_r.oe_mask = 4'h3; // R4
            default: next_r.oe_mask = 4'h2;
          endcase
          if (r.ocnt == 4'h0) begin
            next_r.obits = nib(rd_byte, w);
            next_r.shout = 8'(rd_byte << w);
            next_r.ocnt = 4'd8 - {1'b0, w};
            next_r.adr = r.adr + 24'h1;
          end else begin
            next_r.obits = nib(r.shout, w);
            next_r.shout = 8'(r.shout << w);
            next_r.ocnt = r.ocnt - {1'b0, w};
          end
        end
        default: next_r.oe_mask = 4'h0;
      endcase
    end

    // Hardware reset overrides phase, busy, wel, cmd_ok, oe_mask and array writes
    if (rst_low) begin
      next_r.rcnt = (r.rcnt == `SFM_RST_CNT_W'(RESET_CYCLES)) ? r.rcnt : r.rcnt + 1'b1;
    end else begin
      next_r.rcnt = '0;
    end
    next_r.rst_act = rst_low && (r.rcnt == `SFM_RST_CNT_W'(RESET_CYCLES)); // R14
    if (r.rst_act) begin // R14
      next_r.phase = sfm_pkg::ph_idle;
      next_r.busy = 1'b0;
      next_r.wel = 1'b0;
      next_r.cmd_ok = 1'b0;
      next_r.oe_mask = 4'h0;
      mem_we = 1'b0;
      sec_we = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en && !srst && mem_we) begin
      main_mem[mem_a] <= mem_d;
    end
    if (clk_en && !srst && sec_we) begin
      sec_mem[sec_a] <= sec_d;
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  // Enables also drop on the synchronised select, so no stale drive after deselect
  assign data_line_zero_out = r.obits[0];
  assign data_line_one_out = r.obits[1];
  assign data_line_two_out = r.obits[2];
  assign data_line_three_out = r.obits[3];
  assign data_line_zero_oe = r.oe_mask[0] & ~r.s2.sel_n & ~paused; // R5 R11
  assign data_line_one_oe = r.oe_mask[1] & ~r.s2.sel_n & ~paused; // R5 R11
  assign data_line_two_oe = r.oe_mask[2] & ~r.s2.sel_n & ~paused; // R9
  assign data_line_three_oe = r.oe_mask[3] & ~r.s2.sel_n & ~paused; // R12
  assign reg_rdata = r.rdata;

endmodule : sfm_flash

`default_nettype wire

// File: core/sfm_pkg.sv
`default_nettype none
`include "sfm_consts.svh"

package sfm_pkg;

  typedef enum logic [2:0] {
    ph_idle = 3'h0,
    ph_cmd = 3'h1,
    ph_addr = 3'h3,
    ph_dummy = 3'h2,
    ph_data = 3'h6
  } sfm_phase_t;

  typedef struct packed {
    logic sclk;
    logic sel_n;
    logic rst_n;
    logic [3:0] io;
  } sfm_pins_t;

  typedef struct packed {
    sfm_pins_t s1;
    sfm_pins_t s2;
    logic sclk_q;
    logic sel_q;
    sfm_phase_t phase;
    logic [7:0] op;
    logic [23:0] adr;
    logic [7:0] shin;
    logic [4:0] cnt;
    logic [7:0] shout;
    logic [3:0] ocnt;
    logic [3:0] obits;
    logic [3:0] oe_mask;
    logic armed;
    logic cmd_ok;
    logic st_idx;
    logic wel;
    logic [2:0] bp;
    logic tb;
    logic sec;
    logic status_protect_bits;
    logic cmp;
    logic qe;
    logic pfs;
    logic [2:0] lock;
    logic quad_command_phase_mode;
    logic busy;
    logic busy_sec;
    logic [22:0] eptr;
    logic [22:0] eend;
    logic [`SFM_RST_CNT_W-1:0] rcnt;
    logic rst_act;
    logic [7:0] rdata;
  } sfm_state_t;

endpackage : sfm_pkg

`default_nettype wire

// File: tb/sfm_host.sv
`timescale 1ns/10ps
`default_nettype none

module sfm_host (
  // Link outputs
  output logic serial_clk,
  output logic select_n,
  output logic host_d0,
  output logic host_d0_oe,
  // Wire levels seen by the host
  input wire logic wire_d1,
  input wire logic hold_n
);
  initial begin
    serial_clk = 1'b0;
    select_n = 1'b1;
    host_d0 = 1'b0;
    host_d0_oe = 1'b0;
  end

  // Clock stands still during pause, as a real host must
  task automatic send_bit(input logic b);
    host_d0 = b;
    #40;
    wait (hold_n);
    serial_clk = 1'b1;
    #40 serial_clk = 1'b0;
  endtask : send_bit

  // Standard frame on lines zero and one only, mode 0
  task automatic frame(input logic [39:0] v, input int nb, input int nd, input int nr,
                       output logic [7:0] rd);
    #3 select_n = 1'b0;
    host_d0_oe = 1'b1;
    #40;
    for (int i = 0; i < nb; i++) send_bit(v[39-i]);
    for (int i = 0; i < nd; i++) send_bit(1'b0);
    host_d0_oe = 1'b0;
    rd = 8'h00;
    for (int i = 0; i < 8 * nr; i++) begin
      #40;
      wait (hold_n);
      serial_clk = 1'b1;
      #40 rd = {rd[6:0], wire_d1};
      serial_clk = 1'b0;
    end
    #40 select_n = 1'b1;
    #80;
  endtask : frame
endmodule : sfm_host

`default_nettype wire

// File: tb/sfm_props.sv
`timescale 1ns/10ps
`default_nettype none

module sfm_props #(
  parameter int RESET_CYCLES = 100
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Link pins
  input wire logic serial_clk,
  input wire logic select_n,
  input wire logic dedicated_reset_n,
  input wire logic data_line_two_in,
  input wire logic data_line_three_in,
  input wire logic data_line_one_out,
  input wire logic data_line_zero_oe,
  input wire logic data_line_one_oe,
  input wire logic data_line_two_oe,
  input wire logic data_line_three_oe,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  logic [5:0] s1;
  logic [2:0] lock;
  logic cmp, pfs, qe, seen_hi, any_oe, wr_ok, rst_pin;
  logic [7:0] low_cnt;

  assign any_oe = data_line_zero_oe | data_line_one_oe | data_line_two_oe | data_line_three_oe;
  assign wr_ok = qe | data_line_two_in;
  assign rst_pin = !dedicated_reset_n | (pfs & !qe & !data_line_three_in);

  // ----
  // Shadow status; refused writes leave it alone
  // ----
  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= 6'h00;
      lock <= 3'h0;
      cmp <= 1'b0;
      pfs <= 1'b0;
      qe <= 1'b0;
      seen_hi <= 1'b0;
      low_cnt <= 8'h00;
    end else begin
      if (reg_wr && wr_ok && reg_addr == 2'h0) s1 <= reg_wdata[7:2];
      if (reg_wr && wr_ok && reg_addr == 2'h1) begin
        cmp <= reg_wdata[6];
        lock <= lock | reg_wdata[5:3];
        pfs <= reg_wdata[2];
        qe <= reg_wdata[1];
      end
      if (select_n) seen_hi <= 1'b1;
      low_cnt <= !rst_pin ? 8'h00 : (low_cnt == 8'hff ? low_cnt : low_cnt + 8'h01);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sel_hiz_a: assert property (
    select_n [*4] |=> !any_oe) else $error("line driven while deselected");
  pause_hiz_a: assert property (
    (!qe && !pfs && !data_line_three_in) [*4] |=> !any_oe) else $error("line driven in pause");
  hw_reset_a: assert property (
    low_cnt >= RESET_CYCLES + 4 |-> !any_oe) else $error("line driven under reset");
  lane_limit_a: assert property (
    !qe |-> !data_line_two_oe && !data_line_three_oe) else $error("upper lanes driven");
  out_fall_a: assert property (
    (serial_clk && !select_n) [*4] |-> $stable(data_line_one_out))
    else $error("output moved in high phase");
  status_wp_a: assert property (
    reg_rd && reg_addr == 2'h0 |=> reg_rdata[7:2] == s1) else $error("status one wrong");
  status_otp_a: assert property (
    reg_rd && reg_addr == 2'h1 |=> reg_rdata == {1'b0, cmp, lock, pfs, qe, 1'b0})
    else $error("status two wrong");
  first_sel_a: assert property (
    !seen_hi |-> !any_oe) else $error("driven before first select");
endmodule : sfm_props

bind sfm_flash sfm_props #(.RESET_CYCLES(RESET_CYCLES)) props_u (.*);

`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end

module tb_top;
  typedef struct {logic [7:0] pop, rop; int dmy; logic [23:0] a; logic [7:0] d, e;} sfm_row_t;
  logic clk, srst, flt, reg_wr, reg_rd, sclk, sel_n, h_d0, h_oe, wp_lvl, l3_lvl, rst_n;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd;
  logic [3:0] d_out, d_oe;
  wire logic d0, d1, d2, d3;
  int err_total, tests_run;
  sfm_row_t rows[7] = '{
    '{8'h02, 8'h03, 0, 24'h000100, 8'ha5, 8'ha5},
    '{8'h02, 8'h03, 0, 24'h000100, 8'h0f, 8'h05},
    '{8'h02, 8'h03, 0, 24'h001000, 8'h3c, 8'h3c},
    '{8'h02, 8'h03, 0, 24'h7fffff, 8'h81, 8'h81},
    '{8'h42, 8'h48, 8, 24'h001000, 8'h5a, 8'h5a},
    '{8'h42, 8'h48, 8, 24'h002004, 8'h66, 8'h66},
    '{8'h42, 8'h5a, 8, 24'h000010, 8'h00, 8'hff}};

  // Released lines zero and one show a moving pattern, never the last value
  assign d0 = d_oe[0] ? d_out[0] : (h_oe ? h_d0 : flt);
  assign d1 = d_oe[1] ? d_out[1] : flt;
  assign d2 = d_oe[2] ? d_out[2] : wp_lvl;
  assign d3 = d_oe[3] ? d_out[3] : l3_lvl;

  sfm_flash #(.RESET_CYCLES(4)) dut_u (.clk(clk), .srst(srst), .clk_en(1'b1),
    .serial_clk(sclk), .select_n(sel_n), .dedicated_reset_n(rst_n),
    .data_line_zero_in(d0), .data_line_zero_out(d_out[0]), .data_line_zero_oe(d_oe[0]),
    .data_line_one_in(d1), .data_line_one_out(d_out[1]), .data_line_one_oe(d_oe[1]),
    .data_line_two_in(d2), .data_line_two_out(d_out[2]), .data_line_two_oe(d_oe[2]),
    .data_line_three_in(d3), .data_line_three_out(d_out[3]), .data_line_three_oe(d_oe[3]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  sfm_host host_u (.serial_clk(sclk), .select_n(sel_n), .host_d0(h_d0), .host_d0_oe(h_oe),
    .wire_d1(d1), .hold_n(l3_lvl));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) flt <= ~flt;

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic rw(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : rw

  task automatic rr(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rr

  task automatic op(input logic [39:0] v, input int nb, input int nd, input int nr);
    @(posedge clk);
    host_u.frame(v, nb, nd, nr, rd);
  endtask : op

  task automatic wait_idle;
    logic [7:0] s;
    for (int i = 0; i < 9000; i++) begin
      rr(2'h2, s);
      if (s[0] === 1'b0) return;
    end
    err_total++;
    $display("ERROR t=%0t busy stuck got %h exp %h", $time, s, 8'h00);
    tally_and_finish();
  endtask : wait_idle

  task automatic prog(input logic [7:0] o, input logic [23:0] a, input logic [7:0] d);
    op({8'h06, 32'h0}, 8, 0, 0);
    op({o, a, d}, 40, 0, 0);
    wait_idle();
  endtask : prog

  task automatic erase_start(input logic [23:0] a);
    op({8'h06, 32'h0}, 8, 0, 0);
    op({8'h20, a, 8'h00}, 32, 0, 0);
  endtask : erase_start

  initial begin
    srst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata, flt} = '0;
    {wp_lvl, l3_lvl, rst_n} = 3'b111;
    err_total = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rr(2'h0, rd);
    `CHK(rd, 8'h00)
    rr(2'h1, rd);
    `CHK(rd, 8'h00)
    $display("test reset finished");
    foreach (rows[i]) begin
      prog(rows[i].pop, rows[i].a, rows[i].d);
      op({rows[i].rop, rows[i].a, 8'h00}, 32, rows[i].dmy, 1);
      `CHK(rd, rows[i].e)
    end
    op({8'h03, 24'h001000, 8'h00}, 32, 0, 1);
    `CHK(rd, 8'h3c)
    $display("test table finished");
    wp_lvl <= 1'b0;
    repeat (3) @(posedge clk);
    rw(2'h0, 8'h1c);
    rr(2'h0, rd);
    `CHK(rd, 8'h00)
    wp_lvl <= 1'b1;
    repeat (3) @(posedge clk);
    rw(2'h0, 8'h20);
    rr(2'h0, rd);
    `CHK(rd, 8'h20)
    rw(2'h0, 8'h00);
    $display("test protect finished");
    op({8'h06, 32'h0}, 5, 0, 0);
    rr(2'h0, rd);
    `CHK(rd, 8'h00)
    op({8'h06, 32'h0}, 8, 0, 0);
    rr(2'h0, rd);
    `CHK(rd, 8'h02)
    $display("test partial finished");
    erase_start(24'h000fff);
    rr(2'h2, rd);
    `CHK(rd[0], 1'b1)
    wait_idle();
    op({8'h03, 24'h000100, 8'h00}, 32, 0, 1);
    `CHK(rd, 8'hff)
    op({8'h03, 24'h001000, 8'h00}, 32, 0, 1);
    `CHK(rd, 8'h3c)
    $display("test erase finished");
    fork
      op({8'h03, 24'h001000, 8'h00}, 32, 0, 1);
      begin
        repeat (34) @(posedge sclk);
        @(negedge sclk);
        @(posedge clk);
        l3_lvl <= 1'b0;
        repeat (12) @(posedge clk);
        `CHK(d_oe, 4'h0)
        l3_lvl <= 1'b1;
      end
    join
    `CHK(rd, 8'h3c)
    $display("test pause finished");
    rw(2'h1, 8'h04);
    rr(2'h1, rd);
    `CHK(rd, 8'h04)
    for (int k = 0; k < 2; k++) begin
      erase_start(24'h003000);
      @(posedge clk);
      if (k == 0) l3_lvl <= 1'b0;
      else rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      {l3_lvl, rst_n} <= 2'b11;
      repeat (4) @(posedge clk);
      rr(2'h2, rd);
      `CHK(rd[0], 1'b0)
    end
    $display("test hard reset finished");
    rw(2'h1, 8'h0c);
    rw(2'h1, 8'h04);
    rr(2'h1, rd);
    `CHK(rd, 8'h0c)
    prog(8'h42, 24'h001000, 8'h00);
    op({8'h48, 24'h001000, 8'h00}, 32, 8, 1);
    `CHK(rd, 8'h5a)
    $display("test lock finished");
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
